// ===== hdl/bwd_cfg.svh
// Purpose: Timing and reset constants for the board watchdog timer
// Assumes: System clock of 20 MHz
// Notes:   Unit lengths are derived from the clock rate
`ifndef BWD_CFG_SVH
`define BWD_CFG_SVH

// Clock rate in Hz
`define BWD_CLK_HZ        20000000
// One second, in seconds, and one minute, in seconds
`define BWD_SEC_LEN_S     1
`define BWD_MIN_LEN_S     60
// Cycles per second unit
`define BWD_SEC_CYCLES    (`BWD_CLK_HZ * `BWD_SEC_LEN_S)
// Count reset value
`define BWD_COUNT_RST     8'h00
// Unit select encoding: 0 seconds, 1 minutes
`define BWD_UNIT_MIN      1'b1

`endif

// ===== hdl/bwd_pkg.sv
// Purpose: Types for the board watchdog timer
// Assumes: Nothing beyond the cfg header
// Notes:   Load request carried as one packed struct
package bwd_pkg;

  // Software load of a time-out count
  typedef struct packed {
    logic       valid;
    logic [7:0] count;
  } bwd_load_t;

  // Expiry response selection
  typedef enum logic {
    BWD_ACT_RESET,
    BWD_ACT_NMI
  } bwd_action_t;

  // Timer state
  typedef enum logic [1:0] {
    BWD_IDLE,
    BWD_RUN,
    BWD_FIRE
  } bwd_state_t;

endpackage

// ===== hdl/bwd_timer.sv
// Purpose: Board watchdog: loads a count, counts units down, fires on zero
// Assumes: Load strobe comes from logic on CLK_SYS; unit and action
//          selects are stable setup levels from the same domain
// Notes:   Expiry gives one pulse, then the timer idles until reloaded
`include "bwd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module bwd_timer #(
  parameter int unsigned SEC_CYCLES = `BWD_SEC_CYCLES
) (
  input  wire logic               CLK_SYS,
  input  wire logic               RST,
  input  wire logic               CE,
  input  wire bwd_pkg::bwd_load_t LOAD,
  input  wire logic               UNIT_SEL,
  input  wire bwd_pkg::bwd_action_t ACTION_SEL,
  output logic                    RUNNING,
  output logic [7:0]              COUNT,
  output logic                    COLD_RESET,
  output logic                    NMI
);

  // ************************************************************
  // Unit prescaler
  // ************************************************************
  localparam int unsigned PRE_W = 32;

  bwd_pkg::bwd_state_t state_q;
  logic [PRE_W-1:0]    pre_q;
  logic [5:0]          min_q;
  logic [7:0]          cnt_q;
  logic                sec_tick;
  logic                unit_tick;
  logic                fire_q;
  logic                restart;

  // Restart of the unit timing on any accepted load
  assign restart  = LOAD.valid;
  assign sec_tick = (state_q == bwd_pkg::BWD_RUN) &&
                    (pre_q == PRE_W'(SEC_CYCLES - 1));

  assign unit_tick = sec_tick &&
                     ((UNIT_SEL != `BWD_UNIT_MIN) ||
                      (min_q == 6'(`BWD_MIN_LEN_S - 1)));

  // Second prescaler; cleared by reload so each unit is whole
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pre_q <= '0;
    end else if (CE) begin
      if (restart || sec_tick || state_q != bwd_pkg::BWD_RUN) begin
        pre_q <= '0;
      end else begin
        pre_q <= pre_q + PRE_W'(1);
      end
    end
  end

  // Seconds within a minute
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      min_q <= '0;
    end else if (CE) begin
      // Cleared on every unit tick as well, so a switch to minutes mid-count
      // always gets a whole minute rather than a leftover part of one
      if (restart || unit_tick || state_q != bwd_pkg::BWD_RUN) begin
        min_q <= '0;
      end else if (sec_tick) begin
        min_q <= min_q + 6'h01;
      end
    end
  end

  // ************************************************************
  // Countdown and state
  // ************************************************************
  // Load always wins over a tick landing in the same cycle
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cnt_q   <= `BWD_COUNT_RST;
      state_q <= bwd_pkg::BWD_IDLE;
    end else if (CE) begin
      if (LOAD.valid) begin
        cnt_q <= LOAD.count;
        state_q <= (LOAD.count != 8'h00) ? bwd_pkg::BWD_RUN : bwd_pkg::BWD_IDLE;
      end else begin
        unique case (state_q)
          bwd_pkg::BWD_IDLE: begin
            state_q <= bwd_pkg::BWD_IDLE;
          end
          bwd_pkg::BWD_RUN: begin
            if (unit_tick) begin
              cnt_q <= cnt_q - 8'h01;
              if (cnt_q == 8'h01) begin
                state_q <= bwd_pkg::BWD_FIRE;
              end
            end
          end
          bwd_pkg::BWD_FIRE: begin
            // One-shot expiry; timer stops until reloaded
            state_q <= bwd_pkg::BWD_IDLE;
          end
          default: begin
            state_q <= bwd_pkg::BWD_IDLE;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Expiry outputs
  // ************************************************************
  // registered one-cycle reset or NMI pulse
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      COLD_RESET <= 1'b0;
      NMI        <= 1'b0;
    end else if (CE) begin
      COLD_RESET <= (state_q == bwd_pkg::BWD_FIRE) && (ACTION_SEL == bwd_pkg::BWD_ACT_RESET);
      NMI        <= (state_q == bwd_pkg::BWD_FIRE) && (ACTION_SEL == bwd_pkg::BWD_ACT_NMI);
    end
  end

  // Fire flag mirrors state for the checks below
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      fire_q <= 1'b0;
    end else if (CE) begin
      fire_q <= (state_q == bwd_pkg::BWD_FIRE);
    end
  end

  assign RUNNING = (state_q == bwd_pkg::BWD_RUN);
  assign COUNT   = cnt_q;

  // ************************************************************
  // Check helpers
  // ************************************************************
  // Enabled cycles since the last load or decrement; kept apart from the
  // prescaler so that a wrong prescaler wrap shows up in the unit checks
  logic [PRE_W-1:0] age_q;
  logic             age_min_q;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      age_q <= '0;
    end else if (CE) begin
      if (LOAD.valid || unit_tick || !RUNNING) begin
        age_q <= '0;
      end else begin
        age_q <= age_q + PRE_W'(1);
      end
    end
  end

  // Minute setting seen in the current unit window; a window that mixes
  // settings ends on the next second, so the second-length check skips it
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      age_min_q <= 1'b0;
    end else if (CE) begin
      if (LOAD.valid || unit_tick || !RUNNING) begin
        age_min_q <= 1'b0;
      end else if (UNIT_SEL == `BWD_UNIT_MIN) begin
        age_min_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_last_tick;
    RUNNING && CE && !LOAD.valid && unit_tick && cnt_q == 8'h01;
  endsequence

  a_nonzero_load_runs: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && LOAD.valid && LOAD.count != 8'h00 |=> RUNNING && COUNT == $past(LOAD.count))
    else $error("nonzero load did not start countdown");

  a_expiry_fires: assert property (@(posedge CLK_SYS) disable iff (RST)
    s_last_tick ##1 CE |=> (COLD_RESET || NMI))
    else $error("countdown reached zero without expiry");

  a_action_select: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && fire_q |->
      (COLD_RESET == ($past(ACTION_SEL) == bwd_pkg::BWD_ACT_RESET)) && (NMI != COLD_RESET))
    else $error("expiry response does not match selection");

  a_zero_load_stops: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && LOAD.valid && LOAD.count == 8'h00 |=> !RUNNING ##1 !COLD_RESET && !NMI)
    else $error("zero load did not disable timer");

  a_sec_unit_len: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && RUNNING && !LOAD.valid && unit_tick && !age_min_q && UNIT_SEL != `BWD_UNIT_MIN
      |-> age_q == PRE_W'(SEC_CYCLES - 1))
    else $error("second unit length wrong");

  a_min_unit_len: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && RUNNING && !LOAD.valid && unit_tick && UNIT_SEL == `BWD_UNIT_MIN
      |-> age_q == PRE_W'(`BWD_MIN_LEN_S * SEC_CYCLES - 1))
    else $error("minute unit length wrong");

  a_pulse_one: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && (COLD_RESET || NMI) |=> !COLD_RESET && !NMI)
    else $error("expiry pulse longer than one cycle");

  a_single_dec: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && RUNNING && !LOAD.valid && !unit_tick |=> COUNT == $past(COUNT))
    else $error("count changed without unit tick");

endmodule

`default_nettype wire

// ===== bench/bwd_host.sv
// Purpose: Host software model that loads watchdog counts
// Assumes: Loads are changed at the falling clock edge
// Notes:   One service call gives one single-cycle load strobe
`timescale 1ns/1ps
`default_nettype none
module bwd_host (
  input  wire logic             CLK_SYS,
  output var bwd_pkg::bwd_load_t LOAD
);
  initial LOAD = '0;
  task automatic put(input logic [7:0] c);
    @(negedge CLK_SYS);
    LOAD = {1'b1, c};
    @(negedge CLK_SYS);
    // Released count is scrambled so a stale value cannot pass
    LOAD = {1'b0, ~c};
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the board watchdog
// Assumes: Second unit shortened to SC cycles
// Notes:   Expiry delay is checked to the exact cycle
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int SC = 4;
  logic                 CLK_SYS, RST, CE, UNIT_SEL, RUNNING, COLD_RESET, NMI;
  logic [7:0]           COUNT;
  bwd_pkg::bwd_action_t ACTION_SEL;
  bwd_pkg::bwd_load_t   LOAD;
  int                   n_mismatch, n_compared;
  bwd_timer #(.SEC_CYCLES(SC)) bwd_timer_inst (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE),
    .LOAD(LOAD), .UNIT_SEL(UNIT_SEL), .ACTION_SEL(ACTION_SEL), .RUNNING(RUNNING),
    .COUNT(COUNT), .COLD_RESET(COLD_RESET), .NMI(NMI));
  bwd_host bwd_host_inst (.CLK_SYS(CLK_SYS), .LOAD(LOAD));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  // Cycles in one unit of the count
  function automatic int ucyc(input logic u);
    return u ? 60 * SC : SC;
  endfunction
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Waits for an expiry pulse under a bound; d counts edges
  task automatic wait_fire(input int lim, output int d, output logic [1:0] f);
    d = 0;
    f = 2'h0;
    while (f === 2'h0 && d < lim) begin
      @(posedge CLK_SYS);
      #1;
      d++;
      f = {NMI, COLD_RESET};
    end
  endtask
  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end
  // Watchdog on the bench itself, well past the longest run
  initial begin
    #1000000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    int d, c, e;
    logic [1:0] f;
    RST = 1'b1; CE = 1'b1; UNIT_SEL = 1'b0; ACTION_SEL = bwd_pkg::BWD_ACT_RESET;
    n_mismatch = 0; n_compared = 0;
    void'($urandom(93));
    repeat (6) @(posedge CLK_SYS);
    @(negedge CLK_SYS) RST = 1'b0;
    // Random counts, both actions, minutes at the end
    for (int i = 0; i < 8; i++) begin
      // Setup levels change off the sampling edge
      @(negedge CLK_SYS);
      c = $urandom_range(1, 6);
      UNIT_SEL = (i >= 6);
      ACTION_SEL = bwd_pkg::bwd_action_t'($urandom_range(0, 1));
      bwd_host_inst.put(c[7:0]);
      check("count", COUNT, c);
      e = c * ucyc(UNIT_SEL);
      wait_fire(e + 8, d, f);
      check("delay", d, e + 1);
      check("action", f, ACTION_SEL == bwd_pkg::BWD_ACT_NMI ? 2 : 1);
      check("idle", {RUNNING, COUNT}, 0);
      @(posedge CLK_SYS);
      #1;
      check("pulse", {NMI, COLD_RESET}, 0);
      $display("expiry test %0d done", i);
    end
    // Low enable freezes the countdown and its prescaler
    @(negedge CLK_SYS);
    UNIT_SEL = 1'b0;
    bwd_host_inst.put(8'h02);
    CE = 1'b0;
    repeat (10) @(negedge CLK_SYS);
    check("freeze", COUNT, 8'h02);
    CE = 1'b1;
    wait_fire(2 * SC + 8, d, f);
    check("fdelay", d, 2 * SC + 1);
    $display("enable test done");
    // Largest count, reloaded mid-way: delay runs from the reload
    bwd_host_inst.put(8'hFF);
    repeat (3 * SC) @(negedge CLK_SYS);
    bwd_host_inst.put(8'hFF);
    check("reload", COUNT, 8'hFF);
    wait_fire(255 * SC + 8, d, f);
    check("rdelay", d, 255 * SC + 1);
    $display("reload test done");
    for (int k = 0; k < 4; k++) begin
      bwd_host_inst.put(8'h0A);
      wait_fire(8 * SC, d, f);
      check("alive", f, 0);
    end
    $display("refresh test done");
    bwd_host_inst.put(8'h05);
    repeat (SC) @(negedge CLK_SYS);
    bwd_host_inst.put(8'h00);
    check("stop", RUNNING, 0);
    wait_fire(8 * SC, d, f);
    check("nofire", f, 0);
    $display("disable test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
